// File: logic/ppp_top.sv
// Notes on behaviour
// - Ready flag low during an operation, high when ready for a new command.
// - Load clock rising edge: action bits pick address, data, command or nothing.
// - Address load: first byte select picks high or low address byte.
// - Data load: first byte select picks low or high flash data byte.
// - Write or output-enable strobe runs the last loaded command.
// - Decode erase, fuse, lock, flash and EEPROM write codes.
// - Decode signature, fuse/lock, flash and EEPROM read codes.
// - Data bus driven only while output enable is low.
// - Output enable and write strobe are active low; a write pulse while busy is ignored.
// - Upper byte select picks low byte or second high byte.
// - Page latch pulse stores loaded data into the page buffer.
// - EEPROM 512 bytes, 128 pages of 4; bits 1:0 byte, 8:2 page.
// - Entry pin change within 100 ns after high voltage aborts entry.
// - With lock bits programmed, fuse writes are refused until a chip erase.
// - Mode ends on power down or reset low; re-entry uses normal sequence.
// - Command and address latches hold until explicitly reloaded; leaving the mode clears them.
`timescale 1ns/1ps
`default_nettype none
module ppp_top
	import ppp_pkg::*;
#(
	parameter logic [7:0] FUSE_HIGH_RESET = 8'hff,
	parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value
	parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary value
	parameter logic [7:0] SIG_BYTE2 = 8'h11, // Arbitrary value
	parameter logic [7:0] CAL_BYTE = 8'h80,
	parameter logic [13:0] PROG_HOLD_CYCLES = 14'h0010
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic power_good_i,
	input wire logic hv_reset_i,
	input wire logic prog_load_clock_i,
	input wire logic load_action_sel0_i,
	input wire logic load_action_sel1_i,
	input wire logic byte_select_first_i,
	input wire logic byte_select_upper_i,
	input wire logic page_latch_load_i,
	input wire logic write_strobe_n_i,
	input wire logic output_enable_n_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	output logic prog_ready_flag_o,
	output logic prog_mode_o,
	output logic [7:0] fuse_low_o,
	output logic [7:0] fuse_high_o,
	output logic [7:0] lock_bits_o,
	output logic [3:0] clock_source_fuses_o
);
	import ppp_pkg::*;

	localparam int unsigned SYNC_W = 18;

	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] pin_meta;
	logic [SYNC_W-1:0] pin_sync;
	logic [SYNC_W-1:0] pin_prev;
	logic s_pg, s_hv, s_xclk, s_sel1, s_sel0, s_bs1, s_bs2, s_page_latch_load, s_wr_n, s_oe_n;
	logic [7:0] s_data;
	logic p_pg, p_hv, p_xclk, p_sel1, p_sel0, p_bs1, p_bs2, p_page_latch_load, p_wr_n, p_oe_n;
	logic [7:0] p_data;
	logic xclk_rise, page_latch_load_rise, wr_fall, hv_rise;
	logic [3:0] pattern;

	ppp_entry_t entry;
	logic [7:0] setup_cnt;
	logic [7:0] hold_cnt;
	logic prog_mode;

	ppp_op_t op;
	logic [13:0] op_cnt;
	logic op_ee;
	logic [7:0] cmd;
	logic [7:0] addr_lo, addr_hi;
	logic [7:0] data_lo, data_hi;
	logic [7:0] fuse_low, fuse_high, lock_bits;
	logic can_act;
	logic [13:0] prev_idx;

	ppp_mem_if #(.AW(FLASH_AW), .DW(16)) flash_bus ();
	ppp_mem_if #(.AW(EE_AW), .DW(8)) ee_bus ();
	ppp_mem_if #(.AW(PB_AW), .DW(16)) pb_bus ();

	// Page buffer index for the command in force
	function automatic logic [PB_AW-1:0] pb_index(input logic [7:0] c, input logic [7:0] a);
		if (c == CMD_WRITE_EEPROM) begin
			pb_index = {{(PB_AW - EE_BYTE_W){1'b0}}, a[EE_BYTE_W-1:0]};
		end else begin
			pb_index = a[FLASH_WORD_W-1:0];
		end
	endfunction : pb_index

	// Every pin is foreign to clk_sys_i, so all pass two flops
	assign pin_raw = {power_good_i, hv_reset_i, prog_load_clock_i, load_action_sel1_i,
		load_action_sel0_i, byte_select_first_i, byte_select_upper_i, page_latch_load_i,
		write_strobe_n_i, output_enable_n_i, data_i};
	assign {s_pg, s_hv, s_xclk, s_sel1, s_sel0, s_bs1, s_bs2, s_page_latch_load, s_wr_n, s_oe_n,
		s_data} = pin_sync;
	assign {p_pg, p_hv, p_xclk, p_sel1, p_sel0, p_bs1, p_bs2, p_page_latch_load, p_wr_n, p_oe_n,
		p_data} = pin_prev;

	// Synchroniser and edge history
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_prev <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Edges; a pulse shorter than a few clocks may be missed, hence the width floor
	assign xclk_rise = s_xclk & ~p_xclk;
	assign page_latch_load_rise = s_page_latch_load & ~p_page_latch_load;
	assign wr_fall = ~s_wr_n & p_wr_n;
	assign hv_rise = s_hv & ~p_hv;
	assign pattern = {s_page_latch_load, s_sel1, s_sel0, s_bs1};
	assign prog_mode = (entry == EN_ON);
	assign can_act = prog_mode & (op == OP_IDLE);

	// Time the entry pins have sat at the entry pattern before high voltage
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || pattern != ENTRY_PATTERN) begin
			setup_cnt <= '0;
		end else if (setup_cnt != ENTRY_SETUP_CNT) begin
			setup_cnt <= setup_cnt + 8'h01;
		end
	end

	// Entry sequence; a change on the entry pattern pins while armed spoils it until reset drops
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			entry <= EN_OFF;
			hold_cnt <= '0;
		end else begin
			unique case (entry)
				EN_OFF: begin
					hold_cnt <= '0;
					if (hv_rise && s_pg) begin
						entry <= (setup_cnt == ENTRY_SETUP_CNT) ? EN_ARM : EN_FAIL;
					end
				end
				EN_ARM: begin
					hold_cnt <= hold_cnt + 8'h01;
					if (!s_hv || !s_pg) begin
						entry <= EN_OFF;
					end else if (pattern != ENTRY_PATTERN) begin
						entry <= EN_FAIL;
					end else if (hold_cnt == ENTRY_HOLD_CNT - 8'h01) begin
						entry <= EN_ON;
					end
				end
				EN_ON: begin
					if (!s_hv || !s_pg) begin
						entry <= EN_OFF;
					end
				end
				EN_FAIL: begin
					if (!s_hv || !s_pg) begin
						entry <= EN_OFF;
					end
				end
				default: entry <= EN_OFF;
			endcase
		end
	end

	// Command, address and data latches; loads are ignored while busy
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !prog_mode) begin
			cmd <= CMD_NOP;
			addr_lo <= '0;
			addr_hi <= '0;
			data_lo <= '0;
			data_hi <= '0;
		end else if (can_act && xclk_rise) begin
			unique case (ppp_action_t'({s_sel1, s_sel0}))
				ACT_ADDR: begin
					if (s_bs1) begin
						addr_hi <= s_data;
					end else begin
						addr_lo <= s_data;
					end
				end
				ACT_DATA: begin
					if (s_bs1) begin
						data_hi <= s_data;
					end else begin
						data_lo <= s_data;
					end
				end
				ACT_CMD: cmd <= s_data;
				ACT_IDLE: ;
			endcase
		end
	end

	// Operation sequencer; command and address are left untouched
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			op <= OP_IDLE;
			op_cnt <= '0;
			op_ee <= 1'b0;
		end else if (!prog_mode) begin
			op <= OP_IDLE;
			op_cnt <= '0;
		end else begin
			unique case (op)
				OP_IDLE: begin
					op_cnt <= '0;
					if (wr_fall) begin
						if (cmd == CMD_CHIP_ERASE) begin
							op <= OP_ERASE;
						end else if ((cmd == CMD_WRITE_FLASH || cmd == CMD_WRITE_EEPROM) && !s_bs1) begin
							op <= OP_PAGE;
							op_ee <= (cmd == CMD_WRITE_EEPROM);
						end else if (cmd == CMD_WRITE_LOCK ||
							(cmd == CMD_WRITE_FUSE && lock_bits == LOCK_RESET)) begin
							op <= OP_HOLD;
						end
					end
				end
				OP_PAGE: begin
					op_cnt <= op_cnt + 14'h0001;
					if (op_cnt == (op_ee ? EE_PAGE_LEN : FLASH_PAGE_LEN)) begin
						op <= OP_IDLE;
					end
				end
				OP_ERASE: begin
					op_cnt <= op_cnt + 14'h0001;
					if (op_cnt == ERASE_LAST) begin
						op <= OP_IDLE;
					end
				end
				OP_HOLD: begin
					op_cnt <= op_cnt + 14'h0001;
					if (op_cnt == PROG_HOLD_CYCLES - 14'h0001) begin
						op <= OP_IDLE;
					end
				end
				default: op <= OP_IDLE;
			endcase
		end
	end

	// Fuses and lock bits; locks only ever program further until an erase
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			fuse_low <= FUSE_LOW_RESET;
			fuse_high <= FUSE_HIGH_RESET;
			lock_bits <= LOCK_RESET;
		end else if (op == OP_ERASE && op_cnt == ERASE_LAST) begin
			lock_bits <= LOCK_RESET;
		end else if (can_act && wr_fall) begin
			if (cmd == CMD_WRITE_FUSE && lock_bits == LOCK_RESET) begin
				if (s_bs1) begin
					fuse_high <= data_lo;
				end else begin
					fuse_low <= data_lo;
				end
			end else if (cmd == CMD_WRITE_LOCK) begin
				lock_bits <= lock_bits & data_lo;
			end
		end
	end

	// Page buffer fill on each page latch pulse
	always_comb begin
		pb_bus.we = can_act && page_latch_load_rise &&
			(cmd == CMD_WRITE_FLASH || cmd == CMD_WRITE_EEPROM);
		pb_bus.waddr = pb_index(cmd, addr_lo);
		pb_bus.wdata = {data_hi, data_lo};
		pb_bus.raddr = op_cnt[PB_AW-1:0];
	end

	// Buffer read lags one cycle, so the slot written is the one before
	assign prev_idx = op_cnt - 14'h0001;

	// Flash port: page copy, erase fill, idle read at the loaded address
	always_comb begin
		flash_bus.we = 1'b0;
		flash_bus.waddr = {addr_hi[4:0], addr_lo[7:FLASH_PAGE_LSB], prev_idx[FLASH_WORD_W-1:0]};
		flash_bus.wdata = pb_bus.rdata;
		if (op == OP_PAGE && !op_ee && op_cnt != 14'h0000) begin
			flash_bus.we = 1'b1;
		end else if (op == OP_ERASE) begin
			flash_bus.we = 1'b1;
			flash_bus.waddr = op_cnt[FLASH_AW-1:0];
			flash_bus.wdata = ERASED_WORD;
		end
		flash_bus.raddr = {addr_hi[4:0], addr_lo};
	end

	// EEPROM port; the save fuse keeps contents through an erase
	always_comb begin
		ee_bus.we = 1'b0;
		ee_bus.waddr = {addr_hi[0], addr_lo[7:EE_PAGE_LSB], prev_idx[EE_BYTE_W-1:0]};
		ee_bus.wdata = pb_bus.rdata[7:0];
		if (op == OP_PAGE && op_ee && op_cnt != 14'h0000) begin
			ee_bus.we = 1'b1;
		end else if (op == OP_ERASE && op_cnt < EE_ERASE_END && fuse_high[EESAVE_BIT]) begin
			ee_bus.we = 1'b1;
			ee_bus.waddr = op_cnt[EE_AW-1:0];
			ee_bus.wdata = ERASED_BYTE;
		end
		ee_bus.raddr = {addr_hi[0], addr_lo};
	end

	ppp_mem #(.AW(FLASH_AW), .DW(16)) u_flash (.clk_sys_i(clk_sys_i), .mem_p(flash_bus));
	ppp_mem #(.AW(EE_AW), .DW(8)) u_eeprom (.clk_sys_i(clk_sys_i), .mem_p(ee_bus));
	ppp_mem #(.AW(PB_AW), .DW(16)) u_page_buf (.clk_sys_i(clk_sys_i), .mem_p(pb_bus));

	// Read data register follows the selected source while enable is low
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			data_o <= '0;
		end else if (prog_mode && !s_oe_n) begin
			unique case (cmd)
				CMD_READ_FLASH: data_o <= s_bs1 ? flash_bus.rdata[15:8] : flash_bus.rdata[7:0];
				CMD_READ_EEPROM: data_o <= ee_bus.rdata;
				CMD_READ_SIG: begin
					if (s_bs1) begin
						data_o <= CAL_BYTE;
					end else begin
						unique case (addr_lo[1:0])
							2'h0: data_o <= SIG_BYTE0;
							2'h1: data_o <= SIG_BYTE1;
							default: data_o <= SIG_BYTE2;
						endcase
					end
				end
				CMD_READ_FUSE_LOCK: begin
					unique case ({s_bs2, s_bs1})
						FL_SEL_FUSE_LOW: data_o <= fuse_low;
						FL_SEL_LOCK: data_o <= lock_bits;
						FL_SEL_FUSE_HIGH: data_o <= fuse_high;
						default: data_o <= lock_bits;
					endcase
				end
				default: data_o <= '0;
			endcase
		end
	end

	// Bus turns round as soon as the synced enable goes high again
	assign data_oe_o = prog_mode & ~s_oe_n;
	assign prog_ready_flag_o = (op == OP_IDLE);
	assign prog_mode_o = prog_mode;
	assign fuse_low_o = fuse_low;
	assign fuse_high_o = fuse_high;
	assign lock_bits_o = lock_bits;
	assign clock_source_fuses_o = fuse_low[3:0];
endmodule : ppp_top
`default_nettype wire

// File: logic/ppp_pkg.sv
`default_nettype none
package ppp_pkg;
	// Clock and pin timing
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned PULSE_MIN_NS = 250;
	localparam int unsigned ENTRY_SETUP_NS = 100;
	localparam int unsigned ENTRY_HOLD_NS = 100;
	localparam int unsigned ENTRY_SETUP_CYCLES = (ENTRY_SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned ENTRY_HOLD_CYCLES = (ENTRY_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam logic [7:0] ENTRY_SETUP_CNT = 8'(ENTRY_SETUP_CYCLES);
	localparam logic [7:0] ENTRY_HOLD_CNT = 8'(ENTRY_HOLD_CYCLES);
	localparam logic [3:0] ENTRY_PATTERN = 4'h0;

	// Action select coding on a load clock pulse
	typedef enum logic [1:0] {
		ACT_ADDR = 2'h0,
		ACT_DATA = 2'h1,
		ACT_CMD = 2'h2,
		ACT_IDLE = 2'h3
	} ppp_action_t;

	// Command byte coding
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
	localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
	localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
	localparam logic [7:0] CMD_READ_SIG = 8'h08;
	localparam logic [7:0] CMD_READ_FUSE_LOCK = 8'h04;
	localparam logic [7:0] CMD_READ_FLASH = 8'h02;
	localparam logic [7:0] CMD_READ_EEPROM = 8'h03;

	// Memory geometry
	localparam int unsigned FLASH_AW = 13;
	localparam int unsigned FLASH_WORD_W = 6;
	localparam int unsigned FLASH_PAGE_LSB = 6;
	localparam int unsigned FLASH_WORDS = 8192;
	localparam int unsigned EE_AW = 9;
	localparam int unsigned EE_BYTE_W = 2;
	localparam int unsigned EE_PAGE_LSB = 2;
	localparam int unsigned EE_BYTES = 512;
	localparam int unsigned PB_AW = 6;
	localparam logic [13:0] FLASH_PAGE_LEN = 14'h0040;
	localparam logic [13:0] EE_PAGE_LEN = 14'h0004;
	localparam logic [13:0] ERASE_LAST = 14'(FLASH_WORDS - 1);
	localparam logic [13:0] EE_ERASE_END = 14'(EE_BYTES);

	// Reset and erased values
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [7:0] FUSE_LOW_RESET = 8'he1;
	localparam logic [7:0] LOCK_RESET = 8'hff;
	localparam int unsigned EESAVE_BIT = 3;

	// Fuse and lock read selection by {upper, first}
	localparam logic [1:0] FL_SEL_FUSE_LOW = 2'h0;
	localparam logic [1:0] FL_SEL_LOCK = 2'h1;
	localparam logic [1:0] FL_SEL_FUSE_HIGH = 2'h3;

	// Operation sequencer
	typedef enum logic [3:0] {
		OP_IDLE = 4'b0001,
		OP_PAGE = 4'b0010,
		OP_ERASE = 4'b0100,
		OP_HOLD = 4'b1000
	} ppp_op_t;

	// Programming mode entry
	typedef enum logic [3:0] {
		EN_OFF = 4'b0001,
		EN_ARM = 4'b0010,
		EN_ON = 4'b0100,
		EN_FAIL = 4'b1000
	} ppp_entry_t;
endpackage : ppp_pkg
`default_nettype wire

// File: logic/ppp_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ppp_mem_if #(
	parameter int unsigned AW = 6,
	parameter int unsigned DW = 16
);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport user (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : ppp_mem_if
`default_nettype wire

// File: logic/ppp_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_mem #(
	parameter int unsigned AW = 6,
	parameter int unsigned DW = 16
) (
	input wire logic clk_sys_i,
	ppp_mem_if.mem mem_p
);
	logic [DW-1:0] store [0:(1 << AW) - 1];

	// Nonvolatile arrays start out erased
	initial begin
		for (int i = 0; i < (1 << AW); i++) begin
			store[i] = '1;
		end
	end

	// Registered read, old data returned when read and write hit the same slot
	always_ff @(posedge clk_sys_i) begin
		if (mem_p.we) begin
			store[mem_p.waddr] <= mem_p.wdata;
		end
		mem_p.rdata <= store[mem_p.raddr];
	end
endmodule : ppp_mem
`default_nettype wire

// File: verification/ppp_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_top_chk (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic power_good_i,
	input wire logic hv_reset_i,
	input wire logic load_action_sel0_i,
	input wire logic load_action_sel1_i,
	input wire logic byte_select_first_i,
	input wire logic page_latch_load_i,
	input wire logic output_enable_n_i,
	input wire logic [7:0] data_o,
	input wire logic data_oe_o,
	input wire logic prog_ready_flag_o,
	input wire logic prog_mode_o
);
	logic [3:0] pat;
	logic [7:0] zero_run;
	logic [7:0] hold_run;
	logic [13:0] busy_run;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// Entry pattern pins as one nibble
	assign pat = {page_latch_load_i, load_action_sel1_i, load_action_sel0_i, byte_select_first_i};
	// Setup run of the entry pattern before the high voltage edge
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || pat != 4'h0) begin
			zero_run <= 8'h00;
		end else if (zero_run != 8'hff) begin
			zero_run <= zero_run + 8'h01;
		end
	end
	// Cycles since a clean entry edge; once the pattern moves it stays at zero
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || !hv_reset_i || !power_good_i) begin
			hold_run <= 8'h00;
		end else if ($rose(hv_reset_i)) begin
			hold_run <= (zero_run >= 8'h28 && pat == 4'h0) ? 8'h01 : 8'h00;
		end else if (hold_run != 8'h00 && hold_run != 8'hff) begin
			hold_run <= (pat == 4'h0) ? hold_run + 8'h01 : 8'h00;
		end
	end
	// Length of the current busy stretch
	always_ff @(posedge clk_sys_i) begin
		if (reset_i || prog_ready_flag_o) begin
			busy_run <= 14'h0000;
		end else begin
			busy_run <= busy_run + 14'h0001;
		end
	end
	a_oe_needs_mode: assert property (data_oe_o |-> prog_mode_o)
		else $error("data bus driven outside programming mode");
	a_oe_follows_pin: assert property ((prog_mode_o && !output_enable_n_i) [*4] |-> data_oe_o)
		else $error("data bus not driven during output enable");
	a_oe_released: assert property (output_enable_n_i [*3] |-> !data_oe_o)
		else $error("data bus still driven after output enable");
	a_mode_drops: assert property ($fell(hv_reset_i) |-> ##[1:4] !prog_mode_o)
		else $error("programming mode kept after reset pin low");
	a_no_power_mode: assert property (!power_good_i [*5] |-> !prog_mode_o)
		else $error("programming mode without supply");
	a_entry_abort: assert property ($rose(hv_reset_i) ##[1:16] (pat != 4'h0) |-> ##40 !prog_mode_o)
		else $error("entry accepted despite early pattern change");
	a_entry_time: assert property (hold_run == 8'h28 |-> prog_mode_o)
		else $error("clean entry did not reach programming mode");
	a_busy_bounded: assert property (busy_run < 14'h2010)
		else $error("busy stretch longer than a chip erase");
	a_data_hold: assert property ((prog_mode_o && !data_oe_o) [*3] |-> $stable(data_o))
		else $error("read data moved while bus released");
	c_entry: cover property ($rose(prog_mode_o));
	c_busy: cover property ($fell(prog_ready_flag_o));
	c_read: cover property ($rose(data_oe_o));
endmodule : ppp_top_chk
bind ppp_top ppp_top_chk u_chk (
	.clk_sys_i, .reset_i, .power_good_i, .hv_reset_i, .load_action_sel0_i,
	.load_action_sel1_i, .byte_select_first_i, .page_latch_load_i, .output_enable_n_i,
	.data_o, .data_oe_o, .prog_ready_flag_o, .prog_mode_o
);
`default_nettype wire

// File: verification/ppp_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppp_prog_model (
	input wire logic clk_sys_i,
	input wire logic ready_i,
	input wire logic [7:0] bus_i,
	output logic power_good_o,
	output logic hv_reset_o,
	output logic prog_load_clock_o,
	output logic load_action_sel0_o,
	output logic load_action_sel1_o,
	output logic byte_select_first_o,
	output logic byte_select_upper_o,
	output logic page_latch_load_o,
	output logic write_strobe_n_o,
	output logic output_enable_n_o,
	output logic [7:0] data_o
);
	localparam int PULSE = 64; // 256 ns, clear of the minimum width
	logic [7:0] got;
	event got_ev;
	// Pins idle at time zero
	initial begin
		{power_good_o, hv_reset_o, prog_load_clock_o, page_latch_load_o} = 4'h0;
		{load_action_sel1_o, load_action_sel0_o, byte_select_first_o, byte_select_upper_o} = 4'h0;
		{write_strobe_n_o, output_enable_n_o} = 2'h3;
		data_o = 8'h00;
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc
	// Selects and data settle four cycles either side of the load edge
	task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
		{load_action_sel1_o, load_action_sel0_o} = act;
		byte_select_first_o = bs1;
		data_o = d;
		cyc(4);
		prog_load_clock_o = 1'b1;
		cyc(PULSE);
		prog_load_clock_o = 1'b0;
		cyc(4);
	endtask : load
	task automatic latch_page();
		page_latch_load_o = 1'b1;
		cyc(PULSE);
		page_latch_load_o = 1'b0;
		cyc(4);
	endtask : latch_page
	// Counts busy cycles; returns once ready is back, or after 9000 cycles
	task automatic strobe(output int busy);
		busy = 0;
		byte_select_first_o = 1'b0;
		cyc(4);
		write_strobe_n_o = 1'b0;
		for (int i = 0; i < 9000; i++) begin
			cyc(1);
			busy += int'(!ready_i);
			if (i == PULSE) begin
				write_strobe_n_o = 1'b1;
			end
			if (i > PULSE && ready_i) begin
				break;
			end
		end
	endtask : strobe
	// Bus let go during the read; the stale value is inverted, not kept
	task automatic read(input logic bs1, input logic bs2);
		byte_select_first_o = bs1;
		byte_select_upper_o = bs2;
		cyc(4);
		output_enable_n_o = 1'b0;
		data_o = ~data_o;
		cyc(8);
		got = bus_i;
		-> got_ev;
		cyc(1);
		output_enable_n_o = 1'b1;
		cyc(4);
		byte_select_upper_o = 1'b0;
	endtask : read
	// Alternate entry raises supply together with the high voltage
	task automatic enter(input bit alt, input bit glitch);
		hv_reset_o = 1'b0;
		{page_latch_load_o, load_action_sel1_o, load_action_sel0_o, byte_select_first_o} = 4'h0;
		power_good_o = !alt;
		cyc(8);
		for (int i = 0; i < 6 && !alt; i++) begin
			prog_load_clock_o = 1'b1;
			cyc(PULSE);
			prog_load_clock_o = 1'b0;
			cyc(PULSE);
		end
		cyc(40);
		power_good_o = 1'b1;
		hv_reset_o = 1'b1;
		cyc(5);
		byte_select_first_o = glitch;
		cyc(40);
		byte_select_first_o = 1'b0;
	endtask : enter
	task automatic leave();
		hv_reset_o = 1'b0;
		cyc(8);
	endtask : leave
endmodule : ppp_prog_model
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ppp_pkg::*;
	localparam logic [7:0] SIG0 = 8'ha7; // Arbitrary value
	localparam logic [7:0] SIG1 = 8'h4e; // Arbitrary value
	localparam logic [7:0] SIG2 = 8'hc2; // Arbitrary value
	localparam logic [7:0] CAL = 8'h9b;
	localparam logic [7:0] FHI = 8'hd9;
	localparam logic [13:0] HOLD = 14'h0004;
	logic clk_sys_i, reset_i, power_good_i, hv_reset_i, prog_load_clock_i;
	logic load_action_sel0_i, load_action_sel1_i, byte_select_first_i, byte_select_upper_i;
	logic page_latch_load_i, write_strobe_n_i, output_enable_n_i, data_oe_o;
	logic prog_ready_flag_o, prog_mode_o;
	logic [7:0] data_i, data_o, pdat, fuse_low_o, fuse_high_o, lock_bits_o, pg, ahi, el;
	logic [3:0] clock_source_fuses_o;
	logic [5:0] base;
	logic [15:0] w[4];
	logic [7:0] e[4];
	logic [7:0] sig[3] = '{SIG0, SIG1, SIG2};
	logic [7:0] exp_q[$];
	int seed = 32'hbec0;
	int err_total = 0;
	int tests_run = 0;
	int busy;
	// Bus level: device wins while it drives, else the programmer
	assign data_i = data_oe_o ? data_o : pdat;
	ppp_top #(.FUSE_HIGH_RESET(FHI), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
		.CAL_BYTE(CAL), .PROG_HOLD_CYCLES(HOLD)) DUT (
		.clk_sys_i, .reset_i, .power_good_i, .hv_reset_i, .prog_load_clock_i,
		.load_action_sel0_i, .load_action_sel1_i, .byte_select_first_i, .byte_select_upper_i,
		.page_latch_load_i, .write_strobe_n_i, .output_enable_n_i, .data_i, .data_o,
		.data_oe_o, .prog_ready_flag_o, .prog_mode_o, .fuse_low_o, .fuse_high_o,
		.lock_bits_o, .clock_source_fuses_o
	);
	ppp_prog_model PRG (
		.clk_sys_i, .ready_i(prog_ready_flag_o), .bus_i(data_i), .power_good_o(power_good_i),
		.hv_reset_o(hv_reset_i), .prog_load_clock_o(prog_load_clock_i),
		.load_action_sel0_o(load_action_sel0_i), .load_action_sel1_o(load_action_sel1_i),
		.byte_select_first_o(byte_select_first_i), .byte_select_upper_o(byte_select_upper_i),
		.page_latch_load_o(page_latch_load_i), .write_strobe_n_o(write_strobe_n_i),
		.output_enable_n_o(output_enable_n_i), .data_o(pdat)
	);
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		if (err_total == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_of_test
	task automatic cmd(input logic [7:0] c);
		PRG.load(2'h2, 1'b0, c);
	endtask : cmd
	task automatic rd(input logic [7:0] exp, input logic bs1, input logic bs2);
		exp_q.push_back(exp);
		PRG.read(bs1, bs2);
	endtask : rd
	// Each read result is matched against the oldest expectation
	initial forever begin
		@(PRG.got_ev);
		check("bus", 16'(PRG.got), 16'(exp_q.pop_front()));
	end
	// Hang guard, well beyond the planned run
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		err_total++;
		end_of_test();
	end
	initial begin
		reset_i = 1'b1;
		repeat (16) @(negedge clk_sys_i);
		reset_i = 1'b0;
		check("ready", 16'(prog_ready_flag_o), 16'h0001);
		check("fuses", {fuse_low_o, fuse_high_o}, {FUSE_LOW_RESET, FHI});
		check("lock", 16'(lock_bits_o), 16'h00ff);
		PRG.enter(1'b0, 1'b1);
		check("abort", 16'(prog_mode_o), 16'h0000);
		PRG.leave();
		PRG.enter(1'b0, 1'b0);
		check("entry", 16'(prog_mode_o), 16'h0001);
		// Flash page of four words, then the erased word after them
		ahi = 8'($unsigned($random(seed)) % 32);
		pg = 8'($unsigned($random(seed)) % 4);
		base = 6'($unsigned($random(seed)) % 60);
		cmd(CMD_WRITE_FLASH);
		for (int i = 0; i < 4; i++) begin
			w[i] = 16'($random(seed));
			PRG.load(2'h0, 1'b0, {pg[1:0], base + 6'(i)});
			PRG.load(2'h1, 1'b0, w[i][7:0]);
			PRG.load(2'h1, 1'b1, w[i][15:8]);
			PRG.latch_page();
		end
		PRG.load(2'h0, 1'b1, ahi);
		PRG.strobe(busy);
		check("flash busy", 16'(busy), 16'h0041);
		cmd(CMD_READ_FLASH);
		PRG.load(2'h3, 1'b0, CMD_CHIP_ERASE);
		for (int i = 0; i < 5; i++) begin
			PRG.load(2'h0, 1'b0, {pg[1:0], base + 6'(i)});
			rd(i < 4 ? w[i][7:0] : 8'hff, 1'b0, 1'b0);
			rd(i < 4 ? w[i][15:8] : 8'hff, 1'b1, 1'b0);
		end
		// EEPROM page of four bytes
		el = {6'($random(seed)), 2'h0};
		cmd(CMD_WRITE_EEPROM);
		for (int i = 0; i < 4; i++) begin
			e[i] = 8'($random(seed));
			PRG.load(2'h0, 1'b0, el + 8'(i));
			PRG.load(2'h1, 1'b0, e[i]);
			PRG.latch_page();
		end
		PRG.load(2'h0, 1'b1, 8'($unsigned($random(seed)) % 2));
		PRG.strobe(busy);
		check("eeprom busy", 16'(busy), 16'h0005);
		cmd(CMD_READ_EEPROM);
		for (int i = 0; i < 4; i++) begin
			PRG.load(2'h0, 1'b0, el + 8'(i));
			rd(e[i], 1'b0, 1'b0);
		end
		// Signature bytes and calibration byte
		cmd(CMD_READ_SIG);
		for (int i = 0; i < 3; i++) begin
			PRG.load(2'h0, 1'b0, 8'(i));
			rd(sig[i], 1'b0, 1'b0);
		end
		rd(CAL, 1'b1, 1'b0);
		// Locked part refuses fuse writes until erased
		cmd(CMD_WRITE_LOCK);
		PRG.load(2'h1, 1'b0, 8'hfc);
		PRG.strobe(busy);
		check("lock busy", 16'(busy), 16'(HOLD));
		cmd(CMD_WRITE_FUSE);
		PRG.load(2'h1, 1'b0, 8'h00);
		PRG.strobe(busy);
		check("refused busy", 16'(busy), 16'h0000);
		cmd(CMD_READ_FUSE_LOCK);
		rd(FUSE_LOW_RESET, 1'b0, 1'b0);
		rd(8'hfc, 1'b1, 1'b0);
		rd(FHI, 1'b1, 1'b1);
		cmd(CMD_CHIP_ERASE);
		PRG.strobe(busy);
		check("erase busy", 16'(busy), 16'h2000);
		check("lock", 16'(lock_bits_o), 16'h00ff);
		cmd(CMD_READ_FLASH);
		PRG.load(2'h0, 1'b0, {pg[1:0], base});
		rd(8'hff, 1'b0, 1'b0);
		cmd(CMD_WRITE_FUSE);
		PRG.load(2'h1, 1'b0, 8'he0);
		PRG.strobe(busy);
		check("fuse busy", 16'(busy), 16'(HOLD));
		cmd(CMD_READ_FUSE_LOCK);
		rd(8'he0, 1'b0, 1'b0);
		cmd(CMD_NOP);
		rd(8'h00, 1'b0, 1'b0);
		PRG.leave();
		check("exit", 16'(prog_mode_o), 16'h0000);
		check("clock fuses", 16'(clock_source_fuses_o), 16'h0000);
		// Alternate entry, then a reset in mid-run
		PRG.enter(1'b1, 1'b0);
		check("alt entry", 16'(prog_mode_o), 16'h0001);
		reset_i = 1'b1;
		PRG.cyc(4);
		reset_i = 1'b0;
		PRG.cyc(40);
		check("reset exit", 16'(prog_mode_o), 16'h0000);
		PRG.leave();
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
